//--- design/puo_loader.sv
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// R1: Capture straps only at power-on reset release.
// R2: Load fields once all three resets released.
// R3: Sample REQ64 each PCI reset, set width.
// R4: Reload system controller from grant 3 input.
// R5: Non-power resets restore options from shadow.
// R6: Register image enable, space, base from pins.
// R7: Register image base placed by address space.
// R8: CR/CSR image space and 5-bit page offset.
// R9: CR/CSR upper region internal, lower to PCI.
// R10: Slot identification enables from data pins.
// R11: CR/CSR slot id overrides sysfail option.
// R12: Sysfail driven from reset until cleared.
// R13: Bus isolation restored after every later reset.
// R14: Default PCI target image from pins.
// R15: Other target image settings stay default.
// R16: Address pin 1 selects base register spaces.
// R17: PCI bus master enable from pin 14.
// R18: 32-bit mode keeps driving extension signals.
// R19: Transceivers disabled while any reset active.
// R20: Sample within window, enable one clock later.
// R21: Shadow of straps cleared only by power-on.
// R22: Synchronise reset inputs before use.
module puo_loader (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_power_on_reset_in_n,
  input wire logic i_pci_reset_n,
  input wire logic i_sys_reset_n,
  input wire logic [31:1] i_vme_address_pins,
  input wire logic [31:27] i_vme_data_pins,
  input wire logic i_req64_n,
  input wire logic i_bus_grant3_n,
  input wire logic i_slot_id_sysfail,
  input wire logic i_slot_id_release,
  input wire logic [18:0] i_crcsr_offset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic o_transceiver_output_enable_n,
  output logic o_sysfail_oe,
  output logic o_pci_ext_oe,
  output logic o_pci_64bit,
  output logic o_crcsr_internal,
  output logic [31:0] o_crcsr_pci_addr,
  output logic o_register_image_en,
  output logic [1:0] o_register_image_space,
  output logic [31:12] o_register_image_base,
  output logic o_pci_target_en,
  output logic o_pci_target_local_io,
  output logic [1:0] o_pci_target_space,
  output logic [3:0] o_pci_target_base,
  output logic [3:0] o_pci_target_bound,
  output logic o_bus_isolation_enable,
  output logic o_chain_slot_id_enable,
  output logic o_crcsr_slot_id_enable,
  output logic o_syscon_enable,
  output logic o_pci_base_first_io,
  output logic o_pci_base_second_io,
  output logic o_bus_master_enable
);
  typedef enum logic [1:0] {
    PUO_IDLE, PUO_SAMPLE, PUO_ENABLE
  } puo_cap_e;

  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync_d_reg;
  logic por_act;
  logic pci_act;
  logic sys_act;
  logic any_act;
  puo_cap_e cap_state_reg;
  logic [1:0] cap_cnt_reg;
  logic captured_reg;
  logic xcvr_en_reg;
  logic [31:1] shadow_addr_reg;
  logic [31:27] shadow_data_reg;
  logic load_pend_reg;
  logic [2:0] load_cnt_reg;
  logic load_go;
  logic loaded_reg;
  logic rai_en_reg;
  logic [1:0] rai_vas_reg;
  logic [19:0] rai_base_reg;
  logic csr_las_reg;
  logic [4:0] csr_ofs_reg;
  logic bi_reg;
  logic v64_reg;
  logic chain_reg;
  logic syscon_reg;
  logic sysfail_reg;
  logic lsi_en_reg;
  logic lsi_las_reg;
  logic [1:0] lsi_vas_reg;
  logic [3:0] lsi_bs_reg;
  logic [3:0] lsi_bd_reg;
  logic bs0_io_reg;
  logic bm_reg;
  logic pci64_reg;
  logic [31:0] crcsr_addr_reg;
  logic crcsr_int_reg;
  logic [31:0] rdata_reg;
  logic hit_reg;
  logic wr_acc;
  logic setup;
  logic [31:0] rdata_next;
  logic hit_next;

  // Strapped register image base, upper bits by space
  function automatic logic [19:0] rai_base_f(input logic [1:0] vme_space_select,
                                              input logic [7:0] pins);
    logic [19:0] b;
    b = 20'h00000;
    if (vme_space_select == puo_pkg::VAS_A16) begin
      b[3:0] = pins[7:4]; // R7
    end else if (vme_space_select == puo_pkg::VAS_A24) begin
      b[11:4] = pins; // R7
    end else if (vme_space_select == puo_pkg::VAS_A32) begin
      b[19:12] = pins; // R7
    end
    return b;
  endfunction

  // Reset inputs: two flops each, first flop feeds only the second
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync_d_reg <= 3'h0;
    end else if (i_clk_en) begin
      sync1_reg <= {i_sys_reset_n, i_pci_reset_n, i_power_on_reset_in_n};
      sync2_reg <= sync1_reg; // R22
      sync_d_reg <= sync2_reg;
    end
  end

  assign por_act = !sync2_reg[0];
  assign pci_act = !sync2_reg[1];
  assign sys_act = !sync2_reg[2];
  assign any_act = por_act || pci_act || sys_act;

  // Strap capture after power-on release, then transceivers enabled
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      cap_state_reg <= PUO_IDLE;
      cap_cnt_reg <= 2'h0;
      captured_reg <= 1'b0;
      xcvr_en_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (any_act) begin
        xcvr_en_reg <= 1'b0; // R19
      end
      if (por_act) begin
        cap_state_reg <= PUO_IDLE;
        captured_reg <= 1'b0;
      end else begin
        case (cap_state_reg)
          PUO_IDLE: begin
            if (!captured_reg) begin
              cap_state_reg <= PUO_SAMPLE; // R1
              cap_cnt_reg <= 2'(puo_pkg::SAMPLE_CYC - 1);
            end else if (!any_act) begin
              xcvr_en_reg <= 1'b1;
            end
          end
          PUO_SAMPLE: begin
            if (cap_cnt_reg == 2'h0) begin
              cap_state_reg <= PUO_ENABLE; // R20
              captured_reg <= 1'b1;
            end else begin
              cap_cnt_reg <= cap_cnt_reg - 2'h1;
            end
          end
          PUO_ENABLE: begin
            cap_state_reg <= PUO_IDLE;
            xcvr_en_reg <= !any_act; // R20
          end
          default: cap_state_reg <= PUO_IDLE;
        endcase
      end
    end
  end

  // Shadow is kept across all non-power resets
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en) begin
      if (por_act) begin
        shadow_addr_reg <= '0; // R21
        shadow_data_reg <= '0; // R21
      end else if (cap_state_reg == PUO_SAMPLE && cap_cnt_reg == 2'h0) begin
        shadow_addr_reg <= i_vme_address_pins; // R1
        shadow_data_reg <= i_vme_data_pins; // R1
      end
    end
  end

  // Load once every reset is gone and the straps are captured
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      load_pend_reg <= 1'b1;
      load_cnt_reg <= 3'h0;
      loaded_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (any_act) begin
        load_pend_reg <= 1'b1;
        loaded_reg <= 1'b0;
        load_cnt_reg <= 3'(puo_pkg::LOAD_CYC - 1);
      end else if (load_pend_reg && captured_reg) begin
        if (load_cnt_reg == 3'h0) begin
          load_pend_reg <= 1'b0; // R2
          loaded_reg <= 1'b1;
        end else begin
          load_cnt_reg <= load_cnt_reg - 3'h1;
        end
      end
    end
  end

  assign load_go = !any_act && load_pend_reg && captured_reg &&
                   load_cnt_reg == 3'h0;

  // APB decode
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && hit_reg;

  // Option fields: defaults in reset, shadow values at load
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rai_en_reg <= 1'b0;
      rai_vas_reg <= puo_pkg::VAS_RST;
      rai_base_reg <= puo_pkg::RAI_BASE_RST;
      csr_las_reg <= 1'b0;
      csr_ofs_reg <= puo_pkg::CSR_OFS_RST;
      bi_reg <= 1'b0;
      v64_reg <= 1'b0;
      chain_reg <= 1'b0;
      lsi_en_reg <= 1'b0;
      lsi_las_reg <= 1'b0;
      lsi_vas_reg <= puo_pkg::VAS_RST;
      lsi_bs_reg <= puo_pkg::LSI_ADDR_RST;
      lsi_bd_reg <= puo_pkg::LSI_ADDR_RST;
      bs0_io_reg <= 1'b0;
      bm_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (any_act) begin
        rai_en_reg <= 1'b0;
        rai_vas_reg <= puo_pkg::VAS_RST;
        rai_base_reg <= puo_pkg::RAI_BASE_RST;
        csr_las_reg <= 1'b0;
        csr_ofs_reg <= puo_pkg::CSR_OFS_RST;
        bi_reg <= 1'b0;
        v64_reg <= 1'b0;
        chain_reg <= 1'b0;
        lsi_en_reg <= 1'b0;
        lsi_las_reg <= 1'b0;
        lsi_vas_reg <= puo_pkg::VAS_RST;
        lsi_bs_reg <= puo_pkg::LSI_ADDR_RST;
        lsi_bd_reg <= puo_pkg::LSI_ADDR_RST;
        bm_reg <= 1'b0;
      end else if (load_go) begin
        rai_en_reg <= shadow_addr_reg[31]; // R5 R6
        rai_vas_reg <= shadow_addr_reg[30:29]; // R6
        rai_base_reg <= rai_base_f(shadow_addr_reg[30:29],
                                   shadow_addr_reg[28:21]); // R6
        csr_las_reg <= shadow_addr_reg[20]; // R8
        csr_ofs_reg <= shadow_addr_reg[19:15]; // R8
        chain_reg <= shadow_data_reg[30]; // R10
        v64_reg <= shadow_data_reg[29]; // R10
        bi_reg <= shadow_data_reg[28]; // R13
        lsi_en_reg <= shadow_addr_reg[13]; // R14
        lsi_las_reg <= shadow_addr_reg[12]; // R14
        lsi_vas_reg <= shadow_addr_reg[11:10]; // R14
        lsi_bs_reg <= shadow_addr_reg[9:6]; // R14
        lsi_bd_reg <= shadow_addr_reg[5:2]; // R14
        bs0_io_reg <= !shadow_addr_reg[1]; // R16
        bm_reg <= shadow_addr_reg[14]; // R17
      end else if (wr_acc) begin
        if (paddr == puo_pkg::RAI_CTL_OFS) begin
          rai_en_reg <= pwdata[puo_pkg::RAI_EN_BIT];
          rai_vas_reg <= pwdata[puo_pkg::RAI_VAS_LSB +: 2];
        end else if (paddr == puo_pkg::RAI_BASE_OFS) begin
          rai_base_reg <= pwdata[31:12];
        end else if (paddr == puo_pkg::CSR_CTL_OFS) begin
          csr_las_reg <= pwdata[0];
        end else if (paddr == puo_pkg::CSR_OFS_OFS) begin
          csr_ofs_reg <= pwdata[4:0];
        end else if (paddr == puo_pkg::MISC_OFS) begin
          bi_reg <= pwdata[puo_pkg::MISC_BI_BIT];
          v64_reg <= pwdata[puo_pkg::MISC_V64_BIT];
        end else if (paddr == puo_pkg::LSI_CTL_OFS) begin
          lsi_en_reg <= pwdata[puo_pkg::LSI_EN_BIT];
          lsi_las_reg <= pwdata[puo_pkg::LSI_LAS_BIT];
          lsi_vas_reg <= pwdata[puo_pkg::LSI_VAS_LSB +: 2];
        end else if (paddr == puo_pkg::LSI_BASE_OFS) begin
          lsi_bs_reg <= pwdata[puo_pkg::LSI_ADDR_LSB +: 4];
        end else if (paddr == puo_pkg::LSI_BOUND_OFS) begin
          lsi_bd_reg <= pwdata[puo_pkg::LSI_ADDR_LSB +: 4];
        end else if (paddr == puo_pkg::PCI_CMD_OFS) begin
          bm_reg <= pwdata[puo_pkg::PCI_BM_BIT];
        end
      end
    end
  end

  // Width and system controller come from live pins, not the shadow
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      pci64_reg <= 1'b0;
      syscon_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (sync2_reg[1] && !sync_d_reg[1]) begin
        pci64_reg <= !i_req64_n; // R3
      end
      if (sync2_reg[2] && !sync_d_reg[2]) begin
        syscon_reg <= !i_bus_grant3_n; // R4
      end
    end
  end

  // Sysfail: set wins over a clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      sysfail_reg <= 1'b0;
    end else if (i_clk_en) begin
      if ((por_act && i_vme_data_pins[27]) ||
          (any_act && !por_act && shadow_data_reg[27]) ||
          (wr_acc && paddr == puo_pkg::CSR_SET_OFS && pwdata[0])) begin
        sysfail_reg <= 1'b1; // R12
      end else if ((wr_acc && paddr == puo_pkg::CSR_CLR_OFS && pwdata[0]) ||
                   i_slot_id_release) begin
        sysfail_reg <= 1'b0; // R12
      end
    end
  end

  // CR/CSR routing: translated page plus region select
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      crcsr_addr_reg <= 32'h00000000;
      crcsr_int_reg <= 1'b0;
    end else if (i_clk_en) begin
      crcsr_addr_reg <= {csr_ofs_reg, 8'h00, i_crcsr_offset}; // R8
      crcsr_int_reg <= i_crcsr_offset >= puo_pkg::CRCSR_REG_START; // R9
    end
  end

  // Read data is built in the setup phase and held for the access
  always_comb begin
    rdata_next = 32'h00000000;
    hit_next = 1'b1;
    if (paddr == puo_pkg::RAI_CTL_OFS) begin
      rdata_next[puo_pkg::RAI_EN_BIT] = rai_en_reg;
      rdata_next[puo_pkg::RAI_VAS_LSB +: 2] = rai_vas_reg;
    end else if (paddr == puo_pkg::RAI_BASE_OFS) begin
      rdata_next[31:12] = rai_base_reg;
    end else if (paddr == puo_pkg::CSR_CTL_OFS) begin
      rdata_next[0] = csr_las_reg;
    end else if (paddr == puo_pkg::CSR_OFS_OFS) begin
      rdata_next[4:0] = csr_ofs_reg;
    end else if (paddr == puo_pkg::MISC_OFS) begin
      rdata_next[puo_pkg::MISC_BI_BIT] = bi_reg;
      rdata_next[puo_pkg::MISC_V64_BIT] = v64_reg;
      rdata_next[puo_pkg::MISC_CHAIN_BIT] = chain_reg;
      rdata_next[puo_pkg::MISC_SYSCON_BIT] = syscon_reg;
      rdata_next[puo_pkg::MISC_SIZE_BIT] = pci64_reg;
      rdata_next[puo_pkg::MISC_LOADED_BIT] = loaded_reg;
    end else if (paddr == puo_pkg::CSR_SET_OFS ||
                 paddr == puo_pkg::CSR_CLR_OFS) begin
      rdata_next[0] = o_sysfail_oe;
    end else if (paddr == puo_pkg::LSI_CTL_OFS) begin
      // Offset, posted writes and cycle type read back as zero
      rdata_next[puo_pkg::LSI_EN_BIT] = lsi_en_reg; // R15
      rdata_next[puo_pkg::LSI_LAS_BIT] = lsi_las_reg;
      rdata_next[puo_pkg::LSI_VAS_LSB +: 2] = lsi_vas_reg;
    end else if (paddr == puo_pkg::LSI_BASE_OFS) begin
      rdata_next[puo_pkg::LSI_ADDR_LSB +: 4] = lsi_bs_reg;
    end else if (paddr == puo_pkg::LSI_BOUND_OFS) begin
      rdata_next[puo_pkg::LSI_ADDR_LSB +: 4] = lsi_bd_reg;
    end else if (paddr == puo_pkg::PCI_BS_OFS) begin
      rdata_next[1:0] = {!bs0_io_reg, bs0_io_reg}; // R16
    end else if (paddr == puo_pkg::PCI_CMD_OFS) begin
      rdata_next[puo_pkg::PCI_BM_BIT] = bm_reg;
    end else begin
      hit_next = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rdata_reg <= 32'h00000000;
      hit_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (setup) begin
        rdata_reg <= pwrite ? 32'h00000000 : rdata_next;
        hit_reg <= hit_next;
      end
    end
  end

  assign prdata = rdata_reg;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !hit_reg;

  // Transceivers stay off until strap capture plus one clock
  assign o_transceiver_output_enable_n = !xcvr_en_reg; // R19
  // Identification sequence owns the line when enabled
  assign o_sysfail_oe = v64_reg ? i_slot_id_sysfail : sysfail_reg; // R11
  // Narrow bus still drives the upper half so it never floats
  assign o_pci_ext_oe = !pci64_reg; // R18
  assign o_pci_64bit = pci64_reg;
  assign o_crcsr_internal = crcsr_int_reg;
  assign o_crcsr_pci_addr = crcsr_addr_reg;
  assign o_register_image_en = rai_en_reg;
  assign o_register_image_space = rai_vas_reg;
  assign o_register_image_base = rai_base_reg;
  assign o_pci_target_en = lsi_en_reg;
  assign o_pci_target_local_io = lsi_las_reg;
  assign o_pci_target_space = lsi_vas_reg;
  assign o_pci_target_base = lsi_bs_reg;
  assign o_pci_target_bound = lsi_bd_reg;
  assign o_bus_isolation_enable = bi_reg;
  assign o_chain_slot_id_enable = chain_reg;
  assign o_crcsr_slot_id_enable = v64_reg;
  assign o_syscon_enable = syscon_reg;
  assign o_pci_base_first_io = bs0_io_reg;
  assign o_pci_base_second_io = !bs0_io_reg;
  assign o_bus_master_enable = bm_reg;
endmodule

//--- design/puo_pkg.sv
package puo_pkg;
  // APB register offsets (byte addresses)
  localparam logic [7:0] RAI_CTL_OFS = 8'h00;
  localparam logic [7:0] RAI_BASE_OFS = 8'h04;
  localparam logic [7:0] CSR_CTL_OFS = 8'h08;
  localparam logic [7:0] CSR_OFS_OFS = 8'h0c;
  localparam logic [7:0] MISC_OFS = 8'h10;
  localparam logic [7:0] CSR_SET_OFS = 8'h14;
  localparam logic [7:0] CSR_CLR_OFS = 8'h18;
  localparam logic [7:0] LSI_CTL_OFS = 8'h1c;
  localparam logic [7:0] LSI_BASE_OFS = 8'h20;
  localparam logic [7:0] LSI_BOUND_OFS = 8'h24;
  localparam logic [7:0] PCI_BS_OFS = 8'h28;
  localparam logic [7:0] PCI_CMD_OFS = 8'h2c;
  // Field positions
  localparam int RAI_EN_BIT = 31;
  localparam int RAI_VAS_LSB = 16;
  localparam int MISC_BI_BIT = 0;
  localparam int MISC_V64_BIT = 1;
  localparam int MISC_CHAIN_BIT = 2;
  localparam int MISC_SYSCON_BIT = 3;
  localparam int MISC_SIZE_BIT = 4;
  localparam int MISC_LOADED_BIT = 5;
  localparam int LSI_EN_BIT = 0;
  localparam int LSI_LAS_BIT = 1;
  localparam int LSI_VAS_LSB = 2;
  localparam int LSI_ADDR_LSB = 28;
  localparam int PCI_BM_BIT = 2;
  // Address space codes on the strap pins
  localparam logic [1:0] VAS_A16 = 2'h0;
  localparam logic [1:0] VAS_A24 = 2'h1;
  localparam logic [1:0] VAS_A32 = 2'h2;
  // Reset values
  localparam logic [1:0] VAS_RST = 2'h0;
  localparam logic [19:0] RAI_BASE_RST = 20'h00000;
  localparam logic [4:0] CSR_OFS_RST = 5'h00;
  localparam logic [3:0] LSI_ADDR_RST = 4'h0;
  // Start of the register region inside the 512 Kbyte CR/CSR space
  localparam logic [18:0] CRCSR_REG_START = 19'h7f000;
  // Option sampling window: 31250 ps, about 1.56 clock periods, round down
  localparam int CLK_PS = 20000;
  localparam int SAMPLE_WIN_PS = 31250;
  localparam int SAMPLE_CYC_RAW = SAMPLE_WIN_PS / CLK_PS;
  localparam int SAMPLE_CYC = (SAMPLE_CYC_RAW < 1) ? 1 : SAMPLE_CYC_RAW;
  // Delay from last reset release to loading the option fields
  localparam int LOAD_CYC = 4;
endpackage

//--- tb/puo_straps.sv
`timescale 1ns/1ps
module puo_straps (
  input wire logic i_oe_n,
  input wire logic [31:1] i_a_strap,
  input wire logic [31:27] i_d_strap,
  output logic [31:1] o_a,
  output logic [31:27] o_d
);
  // Straps show only while the transceivers are off; then bus traffic
  assign o_a = i_oe_n ? i_a_strap : ~i_a_strap;
  assign o_d = i_oe_n ? i_d_strap : ~i_d_strap;
endmodule

//--- tb/puo_props.sv
`timescale 1ns/1ps
module puo_props (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_power_on_reset_in_n,
  input wire logic i_pci_reset_n,
  input wire logic i_sys_reset_n,
  input wire logic [31:27] i_vme_data_pins,
  input wire logic i_req64_n,
  input wire logic i_slot_id_sysfail,
  input wire logic i_slot_id_release,
  input wire logic [18:0] i_crcsr_offset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic o_transceiver_output_enable_n,
  input wire logic o_sysfail_oe,
  input wire logic o_pci_ext_oe,
  input wire logic o_pci_64bit,
  input wire logic o_crcsr_internal,
  input wire logic o_crcsr_slot_id_enable,
  input wire logic o_pci_base_first_io,
  input wire logic o_pci_base_second_io
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  logic rs;
  logic wr_set;
  assign rs = i_power_on_reset_in_n && i_pci_reset_n && i_sys_reset_n;
  assign wr_set = psel && penable && pwrite && pwdata[0]
    && paddr == puo_pkg::CSR_SET_OFS;
  sequence por_rel;
    $rose(i_power_on_reset_in_n) && i_pci_reset_n && i_sys_reset_n;
  endsequence
  // Four quiet cycles cover the two-stage reset synchronisers
  sequence quiet;
    rs [*4];
  endsequence
  chk_oe_hold: assert property (
    (!rs) [*4] |-> o_transceiver_output_enable_n)
    else $error("transceivers on in reset");
  chk_oe_open: assert property (
    por_rel ##1 rs [*5] |-> !o_transceiver_output_enable_n)
    else $error("transceivers late");
  chk_width_wide: assert property (
    $rose(i_pci_reset_n) && !i_req64_n ##1 (rs && !i_req64_n) [*8]
    |-> o_pci_64bit) else $error("width not 64");
  chk_ext_drive: assert property (
    $stable(o_pci_64bit) |-> o_pci_ext_oe == !o_pci_64bit)
    else $error("extension drive wrong");
  chk_base_pair: assert property (
    o_pci_base_second_io != o_pci_base_first_io)
    else $error("base spaces equal");
  chk_csr_hit: assert property (
    $past(i_resetn) && $past(i_clk_en) |-> o_crcsr_internal ==
    ($past(i_crcsr_offset) >= puo_pkg::CRCSR_REG_START))
    else $error("region decode wrong");
  chk_id_follow: assert property (
    o_crcsr_slot_id_enable |-> o_sysfail_oe == i_slot_id_sysfail)
    else $error("sysfail ignores slot id");
  chk_fail_set: assert property (
    wr_set && !o_crcsr_slot_id_enable |=> o_sysfail_oe)
    else $error("sysfail set missed");
  chk_fail_rel: assert property (
    quiet ##0 (i_slot_id_release && !wr_set && !o_crcsr_slot_id_enable)
    |=> !o_sysfail_oe) else $error("sysfail release missed");
  chk_fail_por: assert property (
    (!i_power_on_reset_in_n) [*3] ##1
    (!i_power_on_reset_in_n && i_vme_data_pins[27]) |=> o_sysfail_oe)
    else $error("sysfail not driven in reset");
endmodule

//--- tb/puo_loader_tb.sv
`timescale 1ns/1ps
module puo_loader_tb;
  logic i_sys_clk = 1'b0;
  logic i_resetn, por_n, pci_n, sys_n, req_n, bg_n, id_sf, id_rel;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, csr_adr, rd;
  logic [18:0] csr_ofs;
  logic [31:1] a_s, sa, va;
  logic [31:27] d_s, sd, vd;
  logic oe_n, sf, ext, w64, c_int, ri_en, t_en, t_io, bi, chn, v64, sc;
  logic b0io, b1io, bm, e_w64, e_sc, ce;
  logic [1:0] ri_sp, t_sp;
  logic [31:12] ri_bs;
  logic [3:0] t_bs, t_bd;
  int n_errors = 0;
  int check_count = 0;

  always #10 i_sys_clk = ~i_sys_clk;

  puo_straps u_puo_straps (.i_oe_n(oe_n), .i_a_strap(a_s),
    .i_d_strap(d_s), .o_a(va), .o_d(vd));
  puo_loader u_puo_loader (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_clk_en(ce),
    .i_power_on_reset_in_n(por_n), .i_pci_reset_n(pci_n),
    .i_sys_reset_n(sys_n), .i_vme_address_pins(va), .i_vme_data_pins(vd),
    .i_req64_n(req_n), .i_bus_grant3_n(bg_n), .i_slot_id_sysfail(id_sf),
    .i_slot_id_release(id_rel), .i_crcsr_offset(csr_ofs), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .o_transceiver_output_enable_n(oe_n), .o_sysfail_oe(sf),
    .o_pci_ext_oe(ext), .o_pci_64bit(w64), .o_crcsr_internal(c_int),
    .o_crcsr_pci_addr(csr_adr), .o_register_image_en(ri_en),
    .o_register_image_space(ri_sp), .o_register_image_base(ri_bs),
    .o_pci_target_en(t_en), .o_pci_target_local_io(t_io),
    .o_pci_target_space(t_sp), .o_pci_target_base(t_bs),
    .o_pci_target_bound(t_bd), .o_bus_isolation_enable(bi),
    .o_chain_slot_id_enable(chn), .o_crcsr_slot_id_enable(v64),
    .o_syscon_enable(sc), .o_pci_base_first_io(b0io),
    .o_pci_base_second_io(b1io), .o_bus_master_enable(bm));

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    @(posedge i_sys_clk);
    while (pready !== 1'b1) @(posedge i_sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  // Load lands a fixed count after the last release, so a fixed wait
  task automatic rst(input logic p, input logic c, input logic s);
    por_n <= !p;
    pci_n <= !c;
    sys_n <= !s;
    cyc(6);
    por_n <= 1'b1;
    pci_n <= 1'b1;
    sys_n <= 1'b1;
    if (c) e_w64 = !req_n;
    if (s) e_sc = !bg_n;
    cyc(12);
  endtask

  function automatic logic [19:0] exp_bs(input logic [1:0] s,
    input logic [7:0] b);
    case (s)
      puo_pkg::VAS_A16: return {16'h0000, b[7:4]};
      puo_pkg::VAS_A24: return {8'h00, b, 4'h0};
      puo_pkg::VAS_A32: return {b, 12'h000};
      default: return 20'h00000;
    endcase
  endfunction

  task automatic chk_opts;
    chk("oe_n", 32'h0, oe_n);
    chk("ri_ctl", {sa[31], sa[30:29]}, {ri_en, ri_sp});
    chk("ri_bs", exp_bs(sa[30:29], sa[28:21]), ri_bs);
    chk("csr_pg", sa[19:15], csr_adr[31:27]);
    apb(1'b0, puo_pkg::CSR_CTL_OFS, 32'h0);
    chk("csr_io", sa[20], rd[0]);
    chk("tgt", sa[13:2], {t_en, t_io, t_sp, t_bs, t_bd});
    chk("bm", sa[14], bm);
    chk("bs_io", {~sa[1], sa[1]}, {b0io, b1io});
    chk("auto", sd[30:28], {chn, v64, bi});
    chk("width", {e_w64, ~e_w64}, {w64, ext});
    chk("sc", e_sc, sc);
    chk("sf", sd[29] ? id_sf : sd[27], sf);
  endtask

  initial begin
    i_resetn = 1'b0;
    ce = 1'b1;
    por_n = 1'b0;
    pci_n = 1'b0;
    sys_n = 1'b0;
    req_n = 1'b0;
    bg_n = 1'b0;
    id_sf = 1'b1;
    id_rel = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    csr_ofs = 19'h0;
    a_s = 31'h0;
    d_s = 5'h0;
    cyc(10);
    i_resetn <= 1'b1;
    cyc(3);
    for (int s = 0; s < 4; s++) begin
      sa = {s[0], s[1:0], 8'h96, s[0], 5'h13, ~s[0], s[1], s[0], s[1:0],
        4'h9, 4'h6, s[0]};
      sd = {1'b0, s[0], s == 2, s[1], 1'b1};
      a_s <= sa;
      d_s <= sd;
      req_n <= s[0];
      bg_n <= s[1];
      id_sf <= s[0];
      rst(1'b1, 1'b1, 1'b1);
      chk_opts();
    end
    // New straps during later resets must be ignored
    a_s <= ~sa;
    d_s <= ~sd;
    req_n <= 1'b0;
    bg_n <= 1'b0;
    apb(1'b1, puo_pkg::MISC_OFS, 32'h0);
    apb(1'b0, puo_pkg::MISC_OFS, 32'h0);
    chk("misc", 32'h24, rd);
    apb(1'b1, puo_pkg::PCI_CMD_OFS, 32'h4);
    chk("bm_sw", 32'h1, bm);
    apb(1'b1, puo_pkg::PCI_BS_OFS, 32'h3);
    apb(1'b0, puo_pkg::PCI_BS_OFS, 32'h0);
    chk("bs_ro", {30'h0, sa[1], ~sa[1]}, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unm_rd", 32'h0, rd);
    chk("unm_err", 32'h1, err);
    apb(1'b1, puo_pkg::CSR_CLR_OFS, 32'h1);
    chk("sf_clr", 32'h0, sf);
    rst(1'b0, 1'b0, 1'b1);
    chk_opts();
    rst(1'b0, 1'b1, 1'b0);
    chk_opts();
    apb(1'b1, puo_pkg::CSR_CLR_OFS, 32'h1);
    apb(1'b1, puo_pkg::CSR_SET_OFS, 32'h1);
    apb(1'b0, puo_pkg::CSR_CLR_OFS, 32'h0);
    chk("sf_rd", 32'h1, rd);
    id_rel <= 1'b1;
    cyc(1);
    id_rel <= 1'b0;
    cyc(1);
    chk("sf_rel", 32'h0, sf);
    for (int k = 0; k < 2; k++) begin
      csr_ofs <= 19'h7efff + k[18:0];
      cyc(2);
      chk("csr_int", k, c_int);
      chk("csr_adr", {sa[19:15], 8'h00, csr_ofs}, csr_adr);
    end
    // Clock enable low must freeze the registered region select
    ce <= 1'b0;
    csr_ofs <= 19'h00000;
    cyc(3);
    chk("ce_hold", 32'h1, c_int);
    ce <= 1'b1;
    cyc(2);
    chk("ce_run", 32'h0, c_int);
    summarize();
  end

  initial begin
    cyc(5000);
    n_errors++;
    summarize();
  end
endmodule

bind puo_loader puo_props u_puo_props (.i_sys_clk, .i_resetn, .i_clk_en,
  .i_power_on_reset_in_n, .i_pci_reset_n, .i_sys_reset_n, .i_vme_data_pins,
  .i_req64_n, .i_slot_id_sysfail, .i_slot_id_release, .i_crcsr_offset,
  .psel, .penable, .pwrite, .paddr, .pwdata, .o_transceiver_output_enable_n,
  .o_sysfail_oe, .o_pci_ext_oe, .o_pci_64bit, .o_crcsr_internal,
  .o_crcsr_slot_id_enable, .o_pci_base_first_io, .o_pci_base_second_io);
